// File: logic/rtu_consts.svh
`ifndef RTU_CONSTS_SVH
`define RTU_CONSTS_SVH

`define CLK_HZ 125000000
`define BAUD_DEF 19200
// one character on the line: 1 start + 8 data + parity/stop pair = 11 bits
`define CHAR_BITS 11
// silent gap of 3.5 characters, held as half characters
`define GAP_HALF_CHARS 7
`define FN_READ_HOLD 8'h03
`define FN_WRITE_ONE 8'h06
`define EXC_FLAG 8'h80
`define EXC_ILL_FUNC 8'h01
`define EXC_ILL_ADDR 8'h02
`define EXC_ILL_DATA 8'h03
`define EXC_DEV_FAIL 8'h04
`define CRC_POLY 16'ha001
`define CRC_INIT 16'hffff
`define HREG_FIRST 40001
`define HREG_LAST 49999
`define HREG_SPAN 16'd9999
`define ADDR_MAX 8'hf7
`define BCAST_ADDR 8'h00
`define RD_MAX 16'h007d
`define FRAME_MIN 8'h04
`define REQ_LEN 8'h08
`define BUF_BYTES 8
`define TX_FIFO_DEPTH 8
`define T_VOL_MS 20
`define T_PAR_MS 50
`define T_CLR_MS 5000

`endif

// File: logic/rtu_pkg.sv
package rtu_pkg;
   typedef enum logic [3:0] {
      S_RX, S_CHECK, S_WR, S_HDR, S_RDREQ, S_RDWAIT, S_RDH, S_RDL, S_CRCL, S_CRCH, S_END
   } fsm_t;
   typedef enum logic [1:0] {
      CLS_VOLATILE, CLS_PARAM, CLS_CLEAR
   } reg_class_t;
endpackage

// File: logic/rtu_slave_frame_handler.sv
// Summary of operation
// - Register offsets 0..9998 map holding registers 40001 to 49999.
// - Only 8-bit binary bytes are framed; no ASCII framing.
// - Frame is bytes between silent gaps of 3.5 character times.
// - Address 0 is broadcast, 1..247 match the station number setting.
// - Broadcast write queries are executed but never answered.
// - Broadcast executes regardless of the station number setting.
// - Normal answer echoes address and function byte, then data.
// - Exception answer sets bit 7 of function and carries error code.
// - Bad function, register address or data gives exception answer.
// - Reception, framing or CRC errors drop the query silently.
// - Function 1..255 accepted; unsupported codes get an exception.
// - Read holding registers is not executed when broadcast.
// - Volatile accesses finish within 20 ms.
// - Parameter accesses within 50 ms, clear operations within 5 s.
// - CRC sent low byte first; received CRC recomputed and checked.
// - Character: start, 8 data, parity+1 stop or 2 stops.
`include "rtu_consts.svh"

module byte_fifo #(
   parameter int W = 8,
   parameter int DEPTH = `TX_FIFO_DEPTH
) (
   input wire logic clk_sys, // clock
   input wire logic rst, // sync reset
   input wire logic in_valid, // write strobe
   output logic in_ready, // room left
   input wire logic [W-1:0] in_data, // write data
   output logic out_valid, // data present
   input wire logic out_ready, // drain strobe
   output logic [W-1:0] out_data // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW-1:0] rd_nxt;
   logic [AW:0] cnt_r;
   logic [AW:0] cnt_nxt;
   logic val_r;
   logic [W-1:0] head_r;
   logic do_wr;
   logic do_rd;

   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   // head word and valid kept in flops so the outputs leave straight from registers
   assign out_valid = val_r;
   assign out_data = head_r;
   assign do_wr = in_valid && in_ready;
   assign do_rd = val_r && out_ready;
   assign rd_nxt = !do_rd ? rd_r : ((rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1);
   assign cnt_nxt = cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);

   always_ff @(posedge clk_sys)
   begin
      if (do_wr)
      begin
         mem_r[wr_r] <= in_data;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
         val_r <= 1'b0;
         head_r <= '0;
      end
      else
      begin
         if (do_wr)
         begin
            wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
         end
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
         val_r <= (cnt_nxt != '0);
         // a word written into the slot that becomes the head bypasses the array
         head_r <= (do_wr && wr_r == rd_nxt) ? in_data : mem_r[rd_nxt];
      end
   end
endmodule

module rtu_slave_frame_handler #(
   parameter int unsigned BAUD = `BAUD_DEF,
   // least gap, rounded up to whole cycles
   parameter int unsigned GAP_CYCLES = 32'((64'(`CLK_HZ) * `CHAR_BITS * `GAP_HALF_CHARS
      + 64'(2 * BAUD) - 1) / 64'(2 * BAUD)),
   // longest service times, rounded down
   parameter int unsigned LIM_VOL = 32'(64'(`CLK_HZ) * `T_VOL_MS / 1000),
   parameter int unsigned LIM_PAR = 32'(64'(`CLK_HZ) * `T_PAR_MS / 1000),
   parameter int unsigned LIM_CLR = 32'(64'(`CLK_HZ) * `T_CLR_MS / 1000)
) (
   input wire logic clk_sys, // 125 MHz clock
   input wire logic rst, // sync reset, high
   input wire logic [7:0] slave_station_number_setting, // own address
   input wire logic rx_valid, // received character strobe
   input wire logic [7:0] rx_data, // received character
   input wire logic rx_err, // parity, framing or overrun on this character
   output logic tx_valid, // answer byte available
   output logic [7:0] tx_data, // answer byte
   input wire logic tx_ready, // transmitter takes byte
   output logic reg_rd, // register read pulse
   output logic reg_wr, // register write pulse
   output logic [13:0] reg_addr, // register offset from 40001
   output logic [15:0] reg_wdata, // write data
   input wire logic [15:0] reg_rdata, // read data, valid with ack
   input wire logic reg_ack, // access done
   input wire rtu_pkg::reg_class_t reg_class // service class of addressed register
);
   import rtu_pkg::*;

   fsm_t state_r;
   logic [7:0] rxb_r [`BUF_BYTES];
   logic [7:0] len_r;
   logic [15:0] crc_rx_r;
   logic err_r;
   logic active_r;
   logic [31:0] idle_r;
   logic [15:0] tx_crc_r;
   logic [2:0] idx_r;
   logic [2:0] hdr_n_r;
   logic exc_r;
   logic [7:0] code_r;
   logic is_read_r;
   logic [15:0] left_r;
   logic [13:0] addr_r;
   logic [15:0] rdata_r;
   logic [31:0] wait_r;
   logic reg_rd_r;
   logic reg_wr_r;
   logic gap_hit;
   logic frame_good;
   logic bcast;
   logic addr_hit;
   logic [15:0] start;
   logic [15:0] count;
   logic [31:0] limit;
   logic push;
   logic push_ok;
   logic [7:0] push_data;
   logic fifo_in_ready;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] x;
      x = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++)
      begin
         x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
      end
      return x;
   endfunction

   // gap counted in 11-bit characters, valid for all framings
   assign gap_hit = (idle_r == GAP_CYCLES);
   // error or crc mismatch drops the frame; residue of good frame is zero
   assign frame_good = !err_r && (len_r >= `FRAME_MIN) && (crc_rx_r == 16'h0000);
   assign bcast = (rxb_r[0] == `BCAST_ADDR);
   assign addr_hit = bcast
      || ((rxb_r[0] <= `ADDR_MAX) && (rxb_r[0] == slave_station_number_setting));
   assign start = {rxb_r[2], rxb_r[3]};
   assign count = {rxb_r[4], rxb_r[5]};

   always_comb
   begin
      unique case (reg_class)
         CLS_VOLATILE: limit = LIM_VOL;
         CLS_PARAM: limit = LIM_PAR;
         CLS_CLEAR: limit = LIM_CLR;
         default: limit = LIM_VOL;
      endcase
   end

   always_comb
   begin
      push_data = 8'h00;
      unique case (state_r)
         S_HDR:
         begin
            unique case (idx_r)
               3'd0: push_data = rxb_r[0];
               3'd1: push_data = exc_r ? (rxb_r[1] | `EXC_FLAG) : rxb_r[1];
               3'd2: push_data = exc_r ? code_r : (is_read_r ? 8'(count << 1) : rxb_r[2]);
               3'd3: push_data = rxb_r[3];
               3'd4: push_data = rxb_r[4];
               default: push_data = rxb_r[5];
            endcase
         end
         S_RDH: push_data = rdata_r[15:8];
         S_RDL: push_data = rdata_r[7:0];
         S_CRCL: push_data = tx_crc_r[7:0];
         S_CRCH: push_data = tx_crc_r[15:8];
         default: push_data = 8'h00;
      endcase
   end

   assign push = (state_r == S_HDR) || (state_r == S_RDH) || (state_r == S_RDL)
      || (state_r == S_CRCL) || (state_r == S_CRCH);
   assign push_ok = push && fifo_in_ready;

   always_ff @(posedge clk_sys)
   begin
      if (rst || rx_valid)
      begin
         idle_r <= '0;
      end
      else if (!gap_hit)
      begin
         idle_r <= idle_r + 1'b1;
      end
   end

   // collect 8-bit bytes of one frame
   always_ff @(posedge clk_sys)
   begin
      if (rst || state_r == S_END)
      begin
         len_r <= '0;
         crc_rx_r <= `CRC_INIT;
         err_r <= 1'b0;
         active_r <= 1'b0;
      end
      // the byte meeting a closing gap and any byte outside S_RX are lost; after idle a byte opens a frame
      else if (state_r == S_RX && rx_valid && !(active_r && gap_hit))
      begin
         active_r <= 1'b1;
         if (len_r < 8'(`BUF_BYTES))
         begin
            rxb_r[len_r[2:0]] <= rx_data;
         end
         if (len_r != 8'hff)
         begin
            len_r <= len_r + 1'b1;
         end
         crc_rx_r <= crc_step(crc_rx_r, rx_data);
         err_r <= err_r | rx_err;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst || state_r == S_CHECK)
      begin
         tx_crc_r <= `CRC_INIT;
      end
      else if (push_ok && state_r != S_CRCL && state_r != S_CRCH)
      begin
         tx_crc_r <= crc_step(tx_crc_r, push_data);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_r <= S_RX;
         idx_r <= '0;
         hdr_n_r <= 3'd3;
         exc_r <= 1'b0;
         code_r <= 8'h00;
         is_read_r <= 1'b0;
         left_r <= '0;
         addr_r <= '0;
         rdata_r <= '0;
         wait_r <= '0;
         reg_rd_r <= 1'b0;
         reg_wr_r <= 1'b0;
      end
      else
      begin
         reg_rd_r <= 1'b0;
         reg_wr_r <= 1'b0;
         unique case (state_r)
            S_RX:
            begin
               if (active_r && gap_hit)
               begin
                  state_r <= S_CHECK;
               end
            end
            S_CHECK:
            begin
               idx_r <= '0;
               wait_r <= '0;
               exc_r <= 1'b0;
               is_read_r <= 1'b0;
               hdr_n_r <= 3'd3;
               addr_r <= start[13:0];
               left_r <= count;
               if (!frame_good || !addr_hit)
               begin
                  state_r <= S_END;
               end
               else if (rxb_r[1] != `FN_READ_HOLD && rxb_r[1] != `FN_WRITE_ONE)
               begin
                  exc_r <= 1'b1;
                  code_r <= `EXC_ILL_FUNC;
                  state_r <= bcast ? S_END : S_HDR;
               end
               else if (rxb_r[1] == `FN_READ_HOLD && bcast)
               begin
                  state_r <= S_END;
               end
               else if (len_r != `REQ_LEN)
               begin
                  exc_r <= 1'b1;
                  code_r <= `EXC_ILL_DATA;
                  state_r <= bcast ? S_END : S_HDR;
               end
               else if (rxb_r[1] == `FN_READ_HOLD)
               begin
                  is_read_r <= 1'b1;
                  state_r <= S_HDR;
                  if (count == 16'h0000 || count > `RD_MAX)
                  begin
                     exc_r <= 1'b1;
                     code_r <= `EXC_ILL_DATA;
                  end
                  else if (start >= `HREG_SPAN || count > `HREG_SPAN - start)
                  begin
                     exc_r <= 1'b1;
                     code_r <= `EXC_ILL_ADDR;
                  end
               end
               else if (start >= `HREG_SPAN)
               begin
                  exc_r <= 1'b1;
                  code_r <= `EXC_ILL_ADDR;
                  state_r <= bcast ? S_END : S_HDR;
               end
               else
               begin
                  reg_wr_r <= 1'b1;
                  hdr_n_r <= 3'd6;
                  state_r <= S_WR;
               end
            end
            S_WR:
            begin
               wait_r <= wait_r + 1'b1;
               if (reg_ack)
               begin
                  state_r <= bcast ? S_END : S_HDR;
               end
               // no answer in time gives device failure
               else if (wait_r >= limit - 1)
               begin
                  exc_r <= 1'b1;
                  code_r <= `EXC_DEV_FAIL;
                  hdr_n_r <= 3'd3;
                  state_r <= bcast ? S_END : S_HDR;
               end
            end
            S_HDR:
            begin
               if (fifo_in_ready)
               begin
                  idx_r <= idx_r + 1'b1;
                  if (idx_r == hdr_n_r - 1'b1)
                  begin
                     state_r <= (is_read_r && !exc_r) ? S_RDREQ : S_CRCL;
                  end
               end
            end
            S_RDREQ:
            begin
               reg_rd_r <= 1'b1;
               wait_r <= '0;
               state_r <= S_RDWAIT;
            end
            S_RDWAIT:
            begin
               wait_r <= wait_r + 1'b1;
               if (reg_ack)
               begin
                  rdata_r <= reg_rdata;
                  state_r <= S_RDH;
               end
               // header already gone: a late register reads as zero
               else if (wait_r >= limit - 1)
               begin
                  rdata_r <= 16'h0000;
                  state_r <= S_RDH;
               end
            end
            S_RDH:
            begin
               if (fifo_in_ready)
               begin
                  state_r <= S_RDL;
               end
            end
            S_RDL:
            begin
               if (fifo_in_ready)
               begin
                  addr_r <= addr_r + 1'b1;
                  left_r <= left_r - 1'b1;
                  state_r <= (left_r == 16'h0001) ? S_CRCL : S_RDREQ;
               end
            end
            S_CRCL:
            begin
               if (fifo_in_ready)
               begin
                  state_r <= S_CRCH;
               end
            end
            S_CRCH:
            begin
               if (fifo_in_ready)
               begin
                  state_r <= S_END;
               end
            end
            S_END: state_r <= S_RX;
         endcase
      end
   end

   assign reg_rd = reg_rd_r;
   assign reg_wr = reg_wr_r;
   assign reg_addr = addr_r;
   assign reg_wdata = count;

   byte_fifo #(.W(8), .DEPTH(`TX_FIFO_DEPTH)) u_tx_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data)
   );

   property p_bcast_silent;
      @(posedge clk_sys) disable iff (rst) push_ok |-> !bcast;
   endproperty
   a_bcast_silent: assert property (p_bcast_silent) else $error("answer on broadcast");

   property p_exc_bit7;
      @(posedge clk_sys) disable iff (rst)
      (push_ok && state_r == S_HDR && idx_r == 3'd1 && exc_r) |-> push_data[7];
   endproperty
   a_exc_bit7: assert property (p_exc_bit7) else $error("exception without bit 7");

   property p_echo_addr;
      @(posedge clk_sys) disable iff (rst)
      (push_ok && state_r == S_HDR && idx_r == 3'd0) |-> push_data == rxb_r[0];
   endproperty
   a_echo_addr: assert property (p_echo_addr) else $error("address not echoed");

   property p_bad_drop;
      @(posedge clk_sys) disable iff (rst)
      (state_r == S_CHECK && !frame_good) |=> state_r == S_END ##1 state_r == S_RX;
   endproperty
   a_bad_drop: assert property (p_bad_drop) else $error("bad frame not dropped");

   property p_no_bcast_read;
      @(posedge clk_sys) disable iff (rst) reg_rd_r |-> !bcast;
   endproperty
   a_no_bcast_read: assert property (p_no_bcast_read) else $error("broadcast read");

   property p_wait_bound;
      @(posedge clk_sys) disable iff (rst)
      (state_r == S_WR || state_r == S_RDWAIT) |-> wait_r < limit;
   endproperty
   a_wait_bound: assert property (p_wait_bound) else $error("service limit passed");

   property p_gap_end;
      @(posedge clk_sys) disable iff (rst)
      (state_r == S_RX && $past(state_r) == S_RX) ##1 state_r == S_CHECK |-> $past(gap_hit);
   endproperty
   a_gap_end: assert property (p_gap_end) else $error("frame ended before gap");

   property p_range;
      @(posedge clk_sys) disable iff (rst) (reg_rd_r || reg_wr_r) |-> 16'(reg_addr) < `HREG_SPAN;
   endproperty
   a_range: assert property (p_range) else $error("access outside holding area");

   property p_unsup;
      @(posedge clk_sys) disable iff (rst)
      (state_r == S_CHECK && frame_good && addr_hit && !bcast
         && rxb_r[1] != `FN_READ_HOLD && rxb_r[1] != `FN_WRITE_ONE)
      |=> state_r == S_HDR && exc_r && code_r == `EXC_ILL_FUNC;
   endproperty
   a_unsup: assert property (p_unsup) else $error("unsupported code not refused");
endmodule

// File: testbench/rtu_master_model.sv
module rtu_master_model #(
   parameter int GAP = 50
) (
   input wire logic clk_sys, // clock
   output logic rx_valid, // character strobe
   output logic [7:0] rx_data, // character
   output logic rx_err, // character fault flag
   input wire logic tx_valid, // answer byte present
   input wire logic [7:0] tx_data, // answer byte
   output logic tx_ready // answer byte taken
);
   timeunit 1ns;
   timeprecision 1ps;
   typedef logic [7:0] bq_t [$];
   bq_t got;
   logic slow;
   logic [3:0] cyc;

   initial
   begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_err = 1'b0;
      tx_ready = 1'b1;
      slow = 1'b0;
      cyc = 4'h0;
   end

   function automatic logic [15:0] crc16(bq_t q);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i])
      begin
         c ^= {8'h00, q[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      return c;
   endfunction

   task automatic send(bq_t q, int err_at, logic bad, int pause_at);
      logic [15:0] c;
      c = crc16(q) ^ {16{bad}};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      foreach (q[i])
      begin
         if (i == pause_at)
         begin
            @(posedge clk_sys);
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
            repeat (19) @(posedge clk_sys);
         end
         @(posedge clk_sys);
         rx_valid <= 1'b1;
         rx_data <= q[i];
         rx_err <= (i == err_at);
      end
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      rx_err <= 1'b0;
      // stale data would hide a sampling slip
      rx_data <= ~q[q.size() - 1];
      repeat (GAP) @(posedge clk_sys);
   endtask

   // slow mode takes one byte in 16, so the answer fifo fills
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 4'h1;
      tx_ready <= !slow || (cyc == 4'h0);
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         got.push_back(tx_data);
   end
endmodule

// File: testbench/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rtu_pkg::*;
   typedef logic [7:0] bq_t [$];
   localparam int GAP = 50;
   logic clk_sys, rst, rx_valid, rx_err, tx_valid, tx_ready, reg_rd, reg_wr, reg_ack, pend;
   logic [7:0] station, rx_data, tx_data;
   logic [13:0] reg_addr, wa;
   logic [15:0] reg_wdata, reg_rdata, wd;
   reg_class_t reg_class;
   int failures, num_checks, ack_dly, rd_cnt, wr_cnt, wait_cnt;
   bq_t none;

   rtu_slave_frame_handler #(.GAP_CYCLES(GAP), .LIM_VOL(20), .LIM_PAR(30), .LIM_CLR(40)) DUT (
      .clk_sys(clk_sys), .rst(rst), .slave_station_number_setting(station),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .reg_class(reg_class));

   rtu_master_model #(.GAP(GAP)) MST (
      .clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // register side answers ack_dly cycles after the pulse, never if negative
   always @(posedge clk_sys)
   begin
      reg_ack <= 1'b0;
      if (reg_rd === 1'b1 || reg_wr === 1'b1)
      begin
         pend <= 1'b1;
         wait_cnt <= 1;
         rd_cnt <= rd_cnt + int'(reg_rd);
         wr_cnt <= wr_cnt + int'(reg_wr);
         if (reg_wr)
         begin
            wa <= reg_addr;
            wd <= reg_wdata;
         end
      end
      else if (pend && wait_cnt == ack_dly)
      begin
         reg_ack <= 1'b1;
         reg_rdata <= 16'h5a00 ^ {2'b00, reg_addr};
         pend <= 1'b0;
      end
      else
         wait_cnt <= wait_cnt + 1;
   end

   task automatic final_report();
      if (failures == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check_num(logic [15:0] got, logic [15:0] exp, string what);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // waits for the whole answer, then a while longer for stray bytes
   task automatic check_answer(bq_t exp);
      bq_t e;
      logic [15:0] c;
      int n;
      e = exp;
      if (e.size() > 0)
      begin
         c = MST.crc16(e);
         e.push_back(c[7:0]);
         e.push_back(c[15:8]);
      end
      n = 0;
      while (MST.got.size() < e.size() && n < 3000)
      begin
         @(posedge clk_sys);
         n++;
      end
      repeat (150) @(posedge clk_sys);
      num_checks++;
      if (MST.got.size() != e.size())
      begin
         failures++;
         $display("[ERR] %0t answer length %0d exp %0d", $time, MST.got.size(), e.size());
      end
      else
         foreach (e[i])
            check_num({8'h00, MST.got[i]}, {8'h00, e[i]}, "answer byte");
      MST.got.delete();
   endtask

   task automatic frame(bq_t q, bq_t exp, int pause_at);
      MST.send(q, -1, 1'b0, pause_at);
      check_answer(exp);
   endtask

   task automatic t_read();
      @(posedge clk_sys);
      station <= 8'h11;
      reg_class <= CLS_VOLATILE;
      ack_dly = 3;
      MST.slow = 1'b1;
      frame({8'h11, 8'h03, 8'h00, 8'h10, 8'h00, 8'h02},
         {8'h11, 8'h03, 8'h04, 8'h5a, 8'h10, 8'h5a, 8'h11}, -1);
      check_num(16'(rd_cnt), 16'd2, "reads");
      MST.slow = 1'b0;
      frame({8'h11, 8'h03, 8'h27, 8'h0e, 8'h00, 8'h01},
         {8'h11, 8'h03, 8'h02, 8'h7d, 8'h0e}, 3);
      // register too slow: header already gone, data goes out as zero
      ack_dly = 30;
      frame({8'h11, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01},
         {8'h11, 8'h03, 8'h02, 8'h00, 8'h00}, -1);
   endtask

   task automatic t_write();
      reg_class_t cls [3];
      int dly [3];
      cls = '{CLS_PARAM, CLS_VOLATILE, CLS_CLEAR};
      dly = '{25, 25, 35};
      for (int k = 0; k < 3; k++)
      begin
         @(posedge clk_sys);
         reg_class <= cls[k];
         ack_dly = dly[k];
         if (k == 1)
            frame({8'h11, 8'h06, 8'h00, 8'h21, 8'h00, 8'h01},
               {8'h11, 8'h86, 8'h04}, -1);
         else
         begin
            frame({8'h11, 8'h06, 8'h00, 8'h20, 8'h12, 8'h34},
               {8'h11, 8'h06, 8'h00, 8'h20, 8'h12, 8'h34}, -1);
            check_num({2'b00, wa}, 16'h0020, "write address");
            check_num(wd, 16'h1234, "write data");
         end
      end
   endtask

   task automatic t_exc();
      logic [39:0] fr [7];
      logic [7:0] code [7];
      fr = '{40'h41_0000_0001, 40'hff_0000_0001, 40'h03_270f_0001, 40'h03_0000_0000,
         40'h03_0000_007e, 40'h06_270f_1234, 40'h03_270e_0002};
      code = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h03, 8'h02, 8'h02};
      @(posedge clk_sys);
      station <= 8'hf7;
      reg_class <= CLS_VOLATILE;
      ack_dly = 2;
      for (int k = 0; k < 7; k++)
         frame({8'hf7, fr[k][39:32], fr[k][31:24], fr[k][23:16], fr[k][15:8], fr[k][7:0]},
            {8'hf7, fr[k][39:32] | 8'h80, code[k]}, -1);
   endtask

   task automatic t_silent();
      int w0;
      logic [7:0] adr;
      @(posedge clk_sys);
      w0 = wr_cnt;
      for (int k = 0; k < 4; k++)
      begin
         // an own number above 247 must still not be matched
         station <= (k == 3) ? 8'hf8 : 8'h11;
         adr = (k == 2) ? 8'h12 : ((k == 3) ? 8'hf8 : 8'h11);
         MST.send({adr, 8'h06, 8'h00, 8'h40, 8'h00, 8'h07}, (k == 1) ? 2 : -1, k == 0, -1);
         check_answer(none);
      end
      check_num(16'(wr_cnt - w0), 16'd0, "dropped writes");
   endtask

   task automatic t_bcast();
      int w0;
      int r0;
      @(posedge clk_sys);
      reg_class <= CLS_PARAM;
      w0 = wr_cnt;
      r0 = rd_cnt;
      frame({8'h00, 8'h06, 8'h00, 8'h30, 8'hbe, 8'hef}, none, -1);
      check_num(16'(wr_cnt - w0), 16'd1, "broadcast writes");
      check_num({2'b00, wa}, 16'h0030, "broadcast address");
      check_num(wd, 16'hbeef, "broadcast data");
      frame({8'h00, 8'h03, 8'h00, 8'h10, 8'h00, 8'h01}, none, -1);
      frame({8'h00, 8'h41, 8'h00, 8'h10, 8'h00, 8'h01}, none, -1);
      check_num(16'(rd_cnt - r0), 16'd0, "broadcast reads");
   endtask

   initial
   begin
      rst = 1'b1;
      station = 8'h11;
      reg_class = CLS_VOLATILE;
      reg_rdata = 16'h0000;
      reg_ack = 1'b0;
      pend = 1'b0;
      wa = 14'h0000;
      wd = 16'h0000;
      failures = 0;
      num_checks = 0;
      ack_dly = 1;
      rd_cnt = 0;
      wr_cnt = 0;
      wait_cnt = 0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      check_num({14'h0000, reg_rd, reg_wr}, 16'h0000, "idle after reset");
      check_num({15'h0000, tx_valid}, 16'h0000, "empty after reset");
      t_read();
      t_write();
      t_exc();
      t_silent();
      t_bcast();
      final_report();
   end

   // all frames together take well under 20000 cycles
   initial
   begin
      repeat (60000) @(posedge clk_sys);
      failures++;
      final_report();
   end
endmodule
